//--- include/dma_ctrl_defs.vh
// Register offsets, field positions, reset values and widths of the DMA control slice.
`ifndef DMA_CTRL_DEFS_VH
`define DMA_CTRL_DEFS_VH
`define OFF_CONTROLLER_STATUS       32'h40010000
`define OFF_CONTROLLER_CONFIG       32'h40010004
`define OFF_PRIMARY_STRUCT_BASE     32'h40010008
`define OFF_ALTERNATE_STRUCT_BASE   32'h4001000C
`define OFF_SOFTWARE_REQUEST        32'h40010014
`define OFF_REQUEST_MASK_SET        32'h40010020
`define OFF_REQUEST_MASK_CLEAR      32'h40010024
`define POS_CONTROLLER_ON           0
`define RST_CONTROLLER_CONFIG       1'b0
`define RST_PRIMARY_STRUCT_BASE     32'h00000000
`define RST_ALTERNATE_STRUCT_BASE   32'h00000100
`define RST_SOFTWARE_REQUEST        14'h0000
`define RST_REQUEST_MASK            14'h0000
`define CHANNEL_FIELD_WIDTH         14
`define CHANNEL_COUNT_DEFAULT       14
`define STRUCT_STRIDE_LOG2          5
`endif

//--- logic/chan_bit.v
// One channel's software request and request mask bits.
`timescale 1ns/1ns
module chan_bit
(
  input  wire clk_sys,
  input  wire rstn,
  input  wire swreq_set,
  input  wire swreq_done,
  input  wire mask_set,
  input  wire mask_clear,
  output reg  swreq,
  output reg  mask
);

  // Software request: a new write wins over a completion in the same cycle.
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      swreq <= 1'b0;
    else if (swreq_set)
      swreq <= 1'b1;
    else if (swreq_done)
      swreq <= 1'b0;
  end

  // Mask: setting wins if the set and clear strobes are both high in one cycle.
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      mask <= 1'b0;
    else if (mask_set)
      mask <= 1'b1;
    else if (mask_clear)
      mask <= 1'b0;
  end

endmodule

//--- logic/dma_control_request_regs.v
// Control slice of a multi-channel DMA controller: enable, base pointers, requests, masks.
//
// Contract
// - Bit 0 of controller_config enables the controller; writing 0 disables it.
// - Base pointers read as zero while the controller is held in reset.
// - alternate_struct_base is read-only, hardware-derived, reset 0x00000100.
// - Writing 1 to software_request bit C raises a request on channel C.
// - Writing 0 to a software_request bit creates no request.
// - Hardware clears each software request bit once its request completes.
// - Writing 1 to request_mask_set bit C masks channel C peripheral requests.
// - Writing 0 to request_mask_set leaves the mask unchanged.
// - Reading request_mask_set returns 1 for masked channels, 0 otherwise.
// - Writing 1 to request_mask_clear bit C unmasks channel C; 0 does nothing.
// - controller_status bit 0 reflects the controller enable.
`timescale 1ns/1ns
`include "dma_ctrl_defs.vh"
module dma_control_request_regs
#(
  parameter CHANNELS = `CHANNEL_COUNT_DEFAULT
)
(
  input  wire                            clk_sys,
  input  wire                            rstn,
  input  wire [31:0]                     reg_addr,
  input  wire [31:0]                     reg_wdata,
  input  wire                            reg_write,
  input  wire                            reg_read,
  output reg  [31:0]                     reg_rdata,
  input  wire                            ctrl_in_reset,
  input  wire [CHANNELS-1:0]             swreq_done,
  input  wire [CHANNELS-1:0]             periph_req,
  output reg                             controller_on,
  output reg  [31:0]                     primary_base_field,
  output reg  [31:0]                     alternate_base_field,
  output reg  [CHANNELS-1:0]             software_request_bits,
  output reg  [CHANNELS-1:0]             mask_set_bits,
  output reg  [CHANNELS-1:0]             periph_req_gated
);

  // Size of one half of the control structure table: 2^(5 + ceil(log2 channels)) bytes.
  function integer clog2_f;
    input integer v;
    integer i;
    begin
      clog2_f = 0;
      for (i = 1; i < v; i = i * 2)
        clog2_f = clog2_f + 1;
    end
  endfunction
  localparam LOW_BITS = `STRUCT_STRIDE_LOG2 + clog2_f(CHANNELS);

  wire                wr_cfg  = reg_write && (reg_addr == `OFF_CONTROLLER_CONFIG);
  wire                wr_pri  = reg_write && (reg_addr == `OFF_PRIMARY_STRUCT_BASE);
  wire                wr_sw   = reg_write && (reg_addr == `OFF_SOFTWARE_REQUEST);
  wire                wr_mset = reg_write && (reg_addr == `OFF_REQUEST_MASK_SET);
  wire                wr_mclr = reg_write && (reg_addr == `OFF_REQUEST_MASK_CLEAR);
  wire [CHANNELS-1:0] sw_bits;
  wire [CHANNELS-1:0] mask_bits;
  wire [31:0]         next_alt;
  reg  [31:0]         next_rdata;

  // Only the implemented channels take write data; upper bits are dropped.
  genvar c;
  generate
    for (c = 0; c < CHANNELS; c = c + 1)
    begin : g_chan
      chan_bit u_chan
      (
        .clk_sys    (clk_sys),
        .rstn       (rstn),
        .swreq_set  (wr_sw && reg_wdata[c]),
        .swreq_done (swreq_done[c]),
        .mask_set   (wr_mset && reg_wdata[c]),
        .mask_clear (wr_mclr && reg_wdata[c]),
        .swreq      (sw_bits[c]),
        .mask       (mask_bits[c])
      );
    end
  endgenerate

  // Alternate table sits right after the primary one; software never computes it.
  assign next_alt = reg_wdata + (32'h00000001 << LOW_BITS);

  // Controller enable, primary pointer and mirrored outputs.
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      controller_on         <= `RST_CONTROLLER_CONFIG;
      primary_base_field    <= `RST_PRIMARY_STRUCT_BASE;
      alternate_base_field  <= `RST_ALTERNATE_STRUCT_BASE;
      software_request_bits <= {CHANNELS{1'b0}};
      mask_set_bits         <= {CHANNELS{1'b0}};
      periph_req_gated      <= {CHANNELS{1'b0}};
    end
    else
    begin
      if (wr_cfg)
        controller_on <= reg_wdata[`POS_CONTROLLER_ON];
      // Low bits are stored as written; software must keep them zero.
      if (wr_pri)
        primary_base_field <= reg_wdata;
      // Only a pointer write moves it, so the reset value stays until software sets a base.
      if (wr_pri)
        alternate_base_field <= next_alt;
      software_request_bits <= sw_bits;
      mask_set_bits         <= mask_bits;
      // Masked channels' peripheral requests never reach the engine.
      periph_req_gated      <= periph_req & ~mask_bits;
    end
  end

  // Read mux; write-only and unmapped addresses read as zero.
  always @*
  begin
    next_rdata = 32'h00000000;
    case (reg_addr)
      `OFF_CONTROLLER_STATUS:
        next_rdata[`POS_CONTROLLER_ON] = controller_on;
      `OFF_PRIMARY_STRUCT_BASE:
        next_rdata = ctrl_in_reset ? 32'h00000000 : primary_base_field;
      `OFF_ALTERNATE_STRUCT_BASE:
        next_rdata = ctrl_in_reset ? 32'h00000000 : alternate_base_field;
      `OFF_REQUEST_MASK_SET:
        next_rdata[CHANNELS-1:0] = mask_bits;
      default:
        next_rdata = 32'h00000000;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 32'h00000000;
    else if (reg_read)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 32'h00000000;
  end

endmodule

//--- verif/dma_ctrl_sva.sv
// Checker for the register port and mirrored outputs of the DMA control slice.
`timescale 1ns/1ns
`include "dma_ctrl_defs.vh"
module dma_ctrl_sva #(parameter CHANNELS = 14)
(
  input wire                clk_sys, rstn, reg_write, reg_read, ctrl_in_reset, controller_on,
  input wire [31:0]         reg_addr, reg_wdata, reg_rdata, primary_base_field,
  input wire [31:0]         alternate_base_field,
  input wire [CHANNELS-1:0] swreq_done, periph_req, software_request_bits,
  input wire [CHANNELS-1:0] mask_set_bits, periph_req_gated
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Decodes; the bus never reads and writes at once, so these never clash.
  wire [CHANNELS-1:0] w = reg_wdata[CHANNELS-1:0];
  wire wc = reg_write && reg_addr == `OFF_CONTROLLER_CONFIG;
  wire wp = reg_write && reg_addr == `OFF_PRIMARY_STRUCT_BASE;
  wire ws = reg_write && reg_addr == `OFF_SOFTWARE_REQUEST;
  wire wm = reg_write && reg_addr == `OFF_REQUEST_MASK_SET;
  wire wk = reg_write && reg_addr == `OFF_REQUEST_MASK_CLEAR;
  wire rs = reg_read && reg_addr == `OFF_CONTROLLER_STATUS;
  wire rm = reg_read && reg_addr == `OFF_REQUEST_MASK_SET;
  property p_cfg; wc |=> controller_on == $past(reg_wdata[0]); endproperty
  a_cfg: assert property (p_cfg) else $error("enable wrong");
  property p_sta; rs |=> reg_rdata == {31'h0, $past(controller_on)}; endproperty
  a_sta: assert property (p_sta) else $error("status wrong");
  property p_alt; wp |-> ##2 alternate_base_field ==
    $past(reg_wdata, 2) + (32'h1 << (5 + $clog2(CHANNELS))); endproperty
  a_alt: assert property (p_alt) else $error("alternate wrong");
  property p_rm; rm |=> reg_rdata == 32'(mask_set_bits); endproperty
  a_rm: assert property (p_rm) else $error("mask read wrong");
  property p_set; wm |-> ##2 mask_set_bits == ($past(mask_set_bits) | $past(w, 2)); endproperty
  a_set: assert property (p_set) else $error("mask set wrong");
  property p_clr; wk |-> ##2 mask_set_bits == ($past(mask_set_bits) & ~$past(w, 2)); endproperty
  a_clr: assert property (p_clr) else $error("mask clear wrong");
  property p_sw; ws |-> ##2 software_request_bits == ($past(w, 2) |
    ($past(software_request_bits) & ~$past(swreq_done, 2))); endproperty
  a_sw: assert property (p_sw) else $error("request set wrong");
  property p_done; (|swreq_done) && !ws |-> ##2
    (software_request_bits & $past(swreq_done, 2)) == 0; endproperty
  a_done: assert property (p_done) else $error("request not cleared");
endmodule

//--- verif/engine_model.sv
// Stand-in for the transfer engine and the peripherals.
`timescale 1ns/1ns
module engine_model #(parameter CHANNELS = 14, DELAY = 3)
(
  input wire                 clk_sys,
  input wire                 rstn,
  input wire [CHANNELS-1:0]  software_request_bits,
  output reg [CHANNELS-1:0]  swreq_done,
  output wire [CHANNELS-1:0] periph_req
);
  reg [3:0] cnt;
  // Every peripheral requests, so only the mask decides what passes.
  assign periph_req = {CHANNELS{1'b1}};
  // Completes pending requests DELAY+1 cycles after they appear on software_request_bits; a larger DELAY models a slow engine.
  always @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      cnt <= 4'h0;
      swreq_done <= {CHANNELS{1'b0}};
    end
    else
    begin
      swreq_done <= {CHANNELS{1'b0}};
      cnt <= (|software_request_bits) ? cnt + 4'h1 : 4'h0;
      if (cnt == DELAY)
      begin
        swreq_done <= software_request_bits;
        cnt <= 4'h0;
      end
    end
endmodule

//--- verif/testbench.sv
// Self-checking bench for the DMA control slice.
`timescale 1ns/1ns
`include "dma_ctrl_defs.vh"
module testbench;
  localparam CHANNELS = 14;
  reg clk_sys = 0, rstn = 0, reg_write = 0, reg_read = 0, ctrl_in_reset = 0;
  reg [31:0] reg_addr = 32'h0, reg_wdata = 32'h0;
  wire [31:0] reg_rdata, primary_base_field, alternate_base_field;
  wire controller_on;
  wire [CHANNELS-1:0] swreq_done, periph_req, software_request_bits, mask_set_bits;
  wire [CHANNELS-1:0] periph_req_gated;
  integer fails = 0, checks = 0;
  dma_control_request_regs #(.CHANNELS(CHANNELS)) i_dut (.*);
  engine_model #(.CHANNELS(CHANNELS)) i_far (.*);
  // Free-running system clock.
  initial forever #4 clk_sys = ~clk_sys;
  task chk(input string n, input [31:0] e, g);
    begin
      checks = checks + 1;
      if (e !== g)
      begin
        fails = fails + 1;
        $display("[ERR] %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task wr(input [31:0] a, d);
    begin
      @(posedge clk_sys);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_write <= 1'b0;
    end
  endtask
  // Read data stand only in the cycle after the strobe, so it is sampled there.
  task rd(input [31:0] a, e);
    begin
      @(posedge clk_sys);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1 chk("rdata", e, reg_rdata);
    end
  endtask
  task t_regs;
    begin
      rd(`OFF_ALTERNATE_STRUCT_BASE, 32'h00000100);
      rd(32'h40010010, 32'h0);
      wr(`OFF_CONTROLLER_CONFIG, 32'h00000001);
      rd(`OFF_CONTROLLER_STATUS, 32'h1);
      chk("on", 32'h1, controller_on);
      wr(`OFF_CONTROLLER_CONFIG, 32'hFFFFFFFE);
      rd(`OFF_CONTROLLER_STATUS, 32'h0);
    end
  endtask
  task t_base;
    begin
      wr(`OFF_PRIMARY_STRUCT_BASE, 32'h20000400);
      rd(`OFF_PRIMARY_STRUCT_BASE, 32'h20000400);
      chk("primary", 32'h20000400, primary_base_field);
      chk("alternate", 32'h20000600, alternate_base_field);
      rd(`OFF_ALTERNATE_STRUCT_BASE, 32'h20000600);
      ctrl_in_reset <= 1'b1;
      rd(`OFF_PRIMARY_STRUCT_BASE, 32'h0);
      rd(`OFF_ALTERNATE_STRUCT_BASE, 32'h0);
      ctrl_in_reset <= 1'b0;
    end
  endtask
  task t_mask;
    begin
      wr(`OFF_REQUEST_MASK_SET, 32'hFFFFFFFF);
      rd(`OFF_REQUEST_MASK_SET, 32'h00003FFF);
      chk("gated", 32'h0, periph_req_gated);
      wr(`OFF_REQUEST_MASK_CLEAR, 32'h00000001);
      wr(`OFF_REQUEST_MASK_SET, 32'h0);
      rd(`OFF_REQUEST_MASK_SET, 32'h00003FFE);
      chk("gated", 32'h1, periph_req_gated);
    end
  endtask
  task t_sw;
    begin
      wr(`OFF_SOFTWARE_REQUEST, 32'hFFFF2005);
      @(posedge clk_sys);
      #1 chk("swreq", 32'h2005, software_request_bits);
      repeat (8) @(posedge clk_sys);
      #1 chk("swreq", 32'h0, software_request_bits);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // Main sequence after ten cycles of reset.
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs;
    t_base;
    t_mask;
    t_sw;
    give_verdict;
  end
  // Watchdog: the tests need well under a thousand cycles.
  initial
  begin
    #20000;
    fails = fails + 1;
    give_verdict;
  end
endmodule
bind dma_control_request_regs dma_ctrl_sva #(.CHANNELS(CHANNELS)) i_sva (.*);
